// file: hw/pfbw_pkg.sv
// Package: register map, field positions and timing for the flash block writer
package pfbw_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] PFBW_IDX_FLAGS      = 10'h00d;
  localparam logic [9:0] PFBW_IDX_ENABLES    = 10'h08d;
  localparam logic [9:0] PFBW_IDX_INTCTL     = 10'h00b;
  localparam logic [9:0] PFBW_IDX_DATA_LO    = 10'h10c;
  localparam logic [9:0] PFBW_IDX_ADDR_LO    = 10'h10d;
  localparam logic [9:0] PFBW_IDX_DATA_HI    = 10'h10e;
  localparam logic [9:0] PFBW_IDX_ADDR_HI    = 10'h10f;
  localparam logic [9:0] PFBW_IDX_CONTROL    = 10'h18c;
  localparam logic [9:0] PFBW_IDX_UNLOCK     = 10'h18d;
  localparam int         PFBW_ADDR_W         = 12;
  // Field positions
  localparam int         PFBW_BIT_DONE       = 4;
  localparam int         PFBW_BIT_PERIPHERAL_IRQ_GATE       = 6;
  localparam int         PFBW_BIT_GIE        = 7;
  localparam int         PFBW_BIT_START      = 1;
  localparam int         PFBW_BIT_WRITE_ENABLE_BIT       = 2;
  localparam int         PFBW_BIT_ERRFLAG    = 3;
  localparam int         PFBW_BIT_ERASE      = 4;
  localparam int         PFBW_BIT_PGMSEL     = 7;
  // Values
  localparam logic [7:0]  PFBW_UNLOCK_1      = 8'h55;
  localparam logic [7:0]  PFBW_UNLOCK_2      = 8'haa;
  localparam logic [13:0] PFBW_WORD_BLANK    = 14'h3fff;
  localparam logic [7:0]  PFBW_RESET_BYTE    = 8'h00;
  localparam logic [1:0]  PFBW_LAST_SLOT     = 2'h3;
  localparam int          PFBW_WORDS         = 4;
  // Timing: 2 ms long write at 250 MHz
  localparam int          PFBW_CLK_MHZ       = 250;
  localparam int          PFBW_LONG_WRITE_US = 2000;
  localparam int          PFBW_LONG_CYCLES   = PFBW_LONG_WRITE_US * PFBW_CLK_MHZ;
  // Instruction slots: one executes, one is skipped, then the core stalls
  localparam int          PFBW_SKIP_SLOTS    = 2;
endpackage : pfbw_pkg

// file: hw/pfbw_sync.sv
// Three-flop input synchroniser with agree-before-change filter
`timescale 1ns/1ps
module pfbw_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);
  logic [2:0] stage;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage    <= 3'h0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      stage    <= {stage[1:0], async_in};
      // First stage feeds only the second
      if (stage[1] == stage[2]) begin
        sync_out <= stage[2];
      end
    end
  end
endmodule : pfbw_sync

// file: hw/pfbw_writer.sv
// Program flash block writer: buffer, unlock, long write timer, done flag
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Operation
// - Refuse writes into protected flash segments
// - Program only aligned four-word blocks
// - Block write never crosses its boundary
// - Four 14-bit words, selected by address bits
// - Non-last word: copy, clear start bit
// - Last word: copy and begin programming
// - Core runs next instruction, skips following
// - Core halts about 2 ms, clocks run
// - Resume at third instruction after start
// - Buffer words reset to 3FFF afterwards
// - Flag bit 4 holds done flag
// - Flag sets regardless of enables
// - Peripheral gate bit 6 required
module pfbw_writer
  import pfbw_pkg::*;
#(
  parameter int LONG_CYCLES = PFBW_LONG_CYCLES
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  // Register port
  input  wire logic [9:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // Write-protect configuration pins
  input  wire logic [1:0]             write_protect_config,
  // Core instruction interface
  input  wire logic                   instr_retire,
  output logic                        instr_skip,
  output logic                        core_stall,
  // Flash array programming port
  output logic                        flash_prog,
  output logic [PFBW_ADDR_W-1:0]      flash_addr,
  output logic [4*14-1:0]             flash_data,
  input  wire logic                   flash_done_async,
  // Interrupt request to core
  output logic                        irq_req
);
  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0] {PFBW_IDLE, PFBW_SLOTS, PFBW_PROG} pfbw_mode_t;
  typedef struct packed {
    pfbw_mode_t              mode;
    logic [3:0][13:0]        buffer;
    logic [7:0]              data_lo;
    logic [7:0]              data_hi;
    logic [7:0]              addr_lo;
    logic [7:0]              addr_hi;
    logic                    pgm_sel;
    logic                    erase_sel;
    logic                    write_enable_bit;
    logic                    start;
    logic                    err;
    logic                    done_flag;
    logic                    done_en;
    logic                    peripheral_irq_gate;
    logic                    global_irq_enable;
    logic [1:0]              unlock_step;
    logic [1:0]              slots;
    logic [31:0]             timer;
    logic                    timer_hit;
    logic [PFBW_ADDR_W-1:0]  block_base;
    logic [7:0]              rdata;
  } pfbw_state_t;
  pfbw_state_t st;
  pfbw_state_t next_st;
  logic        flash_done;
  logic        prot_hit;
  logic [PFBW_ADDR_W-1:0] word_addr;
  logic [13:0] data_word;
  // ************************************************************
  // Completion input from flash array
  // ************************************************************
  pfbw_sync u_done_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in (flash_done_async),
    .sync_out (flash_done)
  );
  // ************************************************************
  // Protection decode
  // ************************************************************
  assign word_addr = {st.addr_hi[PFBW_ADDR_W-9:0], st.addr_lo};
  assign data_word = {st.data_hi[5:0], st.data_lo};
  // Config 10 protects words below 200h, 01 protects 100h and up, 00 protects all; 11 means none
  always_comb begin
    case (write_protect_config)
      2'h0:    prot_hit = 1'b1;
      2'h1:    prot_hit = word_addr[PFBW_ADDR_W-1:8] != '0;
      2'h2:    prot_hit = word_addr[PFBW_ADDR_W-1:9] == '0;
      default: prot_hit = 1'b0;
    endcase
  end
  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st       = st;
    next_st.rdata = PFBW_RESET_BYTE;
    next_st.timer_hit = 1'b0;
    // Any access other than the second unlock write breaks the sequence
    if (reg_wr || reg_rd) begin
      next_st.unlock_step = 2'h0;
    end
    if (reg_wr) begin
      if (reg_addr == PFBW_IDX_FLAGS) begin
        next_st.done_flag = reg_wdata[PFBW_BIT_DONE];
      end else if (reg_addr == PFBW_IDX_ENABLES) begin
        next_st.done_en = reg_wdata[PFBW_BIT_DONE];
      end else if (reg_addr == PFBW_IDX_INTCTL) begin
        next_st.peripheral_irq_gate = reg_wdata[PFBW_BIT_PERIPHERAL_IRQ_GATE];
        next_st.global_irq_enable  = reg_wdata[PFBW_BIT_GIE];
      end else if (reg_addr == PFBW_IDX_DATA_LO) begin
        next_st.data_lo = reg_wdata;
      end else if (reg_addr == PFBW_IDX_ADDR_LO) begin
        next_st.addr_lo = reg_wdata;
      end else if (reg_addr == PFBW_IDX_DATA_HI) begin
        next_st.data_hi = reg_wdata;
      end else if (reg_addr == PFBW_IDX_ADDR_HI) begin
        next_st.addr_hi = reg_wdata;
      end else if (reg_addr == PFBW_IDX_UNLOCK) begin
        if (reg_wdata == PFBW_UNLOCK_1) begin
          next_st.unlock_step = 2'h1;
        end else if (reg_wdata == PFBW_UNLOCK_2 && st.unlock_step == 2'h1) begin
          next_st.unlock_step = 2'h2;
        end
      end else if (reg_addr == PFBW_IDX_CONTROL) begin
        next_st.pgm_sel   = reg_wdata[PFBW_BIT_PGMSEL];
        next_st.erase_sel = reg_wdata[PFBW_BIT_ERASE];
        next_st.write_enable_bit      = reg_wdata[PFBW_BIT_WRITE_ENABLE_BIT];
        if (!reg_wdata[PFBW_BIT_ERRFLAG]) begin
          next_st.err = 1'b0;
        end
        // Start only right after unlock, enabled, idle
        if (reg_wdata[PFBW_BIT_START] && st.unlock_step == 2'h2
            && reg_wdata[PFBW_BIT_WRITE_ENABLE_BIT] && st.mode == PFBW_IDLE
            && reg_wdata[PFBW_BIT_PGMSEL] && !reg_wdata[PFBW_BIT_ERASE]) begin
          if (prot_hit) begin
            next_st.err = 1'b1;
          end else begin
            next_st.buffer[st.addr_lo[1:0]] = data_word;
            next_st.start = 1'b1;
            if (st.addr_lo[1:0] == PFBW_LAST_SLOT) begin
              // Base forced to the aligned block start
              next_st.block_base = {word_addr[PFBW_ADDR_W-1:2], 2'h0};
              next_st.mode       = PFBW_SLOTS;
              next_st.slots      = 2'(PFBW_SKIP_SLOTS);
            end
          end
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == PFBW_IDX_FLAGS) begin
        next_st.rdata[PFBW_BIT_DONE] = st.done_flag;
      end else if (reg_addr == PFBW_IDX_ENABLES) begin
        next_st.rdata[PFBW_BIT_DONE] = st.done_en;
      end else if (reg_addr == PFBW_IDX_INTCTL) begin
        next_st.rdata[PFBW_BIT_PERIPHERAL_IRQ_GATE] = st.peripheral_irq_gate;
        next_st.rdata[PFBW_BIT_GIE]  = st.global_irq_enable;
      end else if (reg_addr == PFBW_IDX_DATA_LO) begin
        next_st.rdata = st.data_lo;
      end else if (reg_addr == PFBW_IDX_ADDR_LO) begin
        next_st.rdata = st.addr_lo;
      end else if (reg_addr == PFBW_IDX_DATA_HI) begin
        next_st.rdata = {2'h0, st.data_hi[5:0]};
      end else if (reg_addr == PFBW_IDX_ADDR_HI) begin
        next_st.rdata = st.addr_hi;
      end else if (reg_addr == PFBW_IDX_CONTROL) begin
        next_st.rdata = {st.pgm_sel, 2'h0, st.erase_sel, st.err, st.write_enable_bit, st.start, 1'b0};
      end
    end
    // Short write: start bit lasts one cycle
    if (st.start && st.mode == PFBW_IDLE) begin
      next_st.start = 1'b0;
    end
    case (st.mode)
      PFBW_SLOTS: begin
        if (instr_retire) begin
          next_st.slots = st.slots - 2'h1;
          if (st.slots == 2'h1) begin
            next_st.mode  = PFBW_PROG;
            next_st.timer = 32'h0;
          end
        end
      end
      PFBW_PROG: begin
        next_st.timer = st.timer + 32'h1;
        // Ends on array done or on the nominal time, whichever first
        if (flash_done || st.timer >= 32'(LONG_CYCLES - 1)) begin
          next_st.mode      = PFBW_IDLE;
          next_st.start     = 1'b0;
          next_st.timer_hit = 1'b1;
          for (int i = 0; i < PFBW_WORDS; i++) begin
            next_st.buffer[i] = PFBW_WORD_BLANK;
          end
          next_st.done_flag = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end
  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st            <= '0;
      st.mode       <= PFBW_IDLE;
      st.buffer     <= {PFBW_WORDS{PFBW_WORD_BLANK}};
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata  = st.rdata;
  assign instr_skip = st.mode == PFBW_SLOTS && st.slots == 2'h1;
  assign core_stall = st.mode == PFBW_PROG;
  assign flash_prog = st.mode == PFBW_PROG;
  assign flash_addr = st.block_base;
  assign flash_data = st.buffer;
  assign irq_req    = st.done_flag && st.done_en && st.peripheral_irq_gate && st.global_irq_enable;
  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_long_start;
    st.mode == PFBW_IDLE ##1 st.mode == PFBW_SLOTS;
  endsequence
  AST_STALL_ONLY_PROG: assert property (@(posedge core_clk) disable iff (!reset_n)
    core_stall |-> st.mode == PFBW_PROG && !st.start == 1'b0)
    else $error("stall outside long write");
  AST_BLANK_AFTER: assert property (@(posedge core_clk) disable iff (!reset_n)
    st.timer_hit |-> st.buffer == {PFBW_WORDS{PFBW_WORD_BLANK}})
    else $error("buffer not blank after long write");
  AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    st.timer_hit |-> st.done_flag)
    else $error("done flag missing");
  AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!reset_n)
    irq_req |-> st.peripheral_irq_gate && st.done_en)
    else $error("irq without gate");
  AST_SHORT_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && st.start && st.mode == PFBW_IDLE |=> !st.start)
    else $error("start bit held");
  AST_ALIGNED: assert property (@(posedge core_clk) disable iff (!reset_n)
    flash_prog |-> flash_addr[1:0] == 2'h0)
    else $error("unaligned block");
  AST_PROT: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_long_start |-> $past(!prot_hit))
    else $error("protected write started");
  AST_ENABLED: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(st.start) |-> $past(st.unlock_step) == 2'h2)
    else $error("start without unlock");
endmodule : pfbw_writer

// file: verif/test_pfbw_writer.sv
// Self-checking testbench for the program flash block writer
`timescale 1ns/1ps
module test_pfbw_writer;
  import pfbw_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int          LONG  = 20;
  localparam logic [55:0] BLANK = {4{PFBW_WORD_BLANK}};
  typedef struct packed {
    logic [9:0] a;
    logic [7:0] d;
    logic       w;
    logic [7:0] e;
  } pfbw_row_t;
  logic                   core_clk;
  logic                   reset_n;
  logic [9:0]             reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_rdata;
  logic [1:0]             write_protect_config;
  logic                   instr_retire;
  logic                   instr_skip;
  logic                   core_stall;
  logic                   flash_prog;
  logic [PFBW_ADDR_W-1:0] flash_addr;
  logic [55:0]            flash_data;
  logic                   irq_req;
  logic                   clk_en;
  logic                   flash_done_async;
  int                     mismatches;
  int                     compares;
  logic [7:0]             v;
  pfbw_row_t              rows [9];
  // ************************************************************
  // Design and clock
  // ************************************************************
  pfbw_writer #(.LONG_CYCLES(LONG)) i_pfbw_writer (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .write_protect_config(write_protect_config),
    .instr_retire(instr_retire), .instr_skip(instr_skip), .core_stall(core_stall),
    .flash_prog(flash_prog), .flash_addr(flash_addr), .flash_data(flash_data),
    .flash_done_async(flash_done_async), .irq_req(irq_req));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Let the launching edge settle before anyone looks
    #1;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic retire;
    @(posedge core_clk);
    instr_retire <= 1'b1;
    @(posedge core_clk);
    instr_retire <= 1'b0;
    #1;
  endtask : retire
  // Address and data first, so the unlock pair sits right before the start
  task automatic load(input logic [11:0] a, input logic [13:0] w, input logic unl);
    wr(PFBW_IDX_ADDR_HI, {4'h0, a[11:8]});
    wr(PFBW_IDX_ADDR_LO, a[7:0]);
    wr(PFBW_IDX_DATA_HI, {2'h0, w[13:8]});
    wr(PFBW_IDX_DATA_LO, w[7:0]);
    if (unl) wr(PFBW_IDX_UNLOCK, PFBW_UNLOCK_1);
    if (unl) wr(PFBW_IDX_UNLOCK, PFBW_UNLOCK_2);
    wr(PFBW_IDX_CONTROL, 8'h86);
  endtask : load
  task automatic block(input logic [11:0] base, input logic [13:0] w0);
    logic [55:0] ex;
    logic [7:0]  c;
    int          n;
    for (int i = 0; i < 4; i++) begin
      load(base + 12'(i), w0 + 14'(i), 1'b1);
      ex[i*14 +: 14] = w0 + 14'(i);
      chk("buffer word", w0 + 14'(i), flash_data[i*14 +: 14]);
      if (i < 3) begin
        rd(PFBW_IDX_CONTROL, c);
        chk("start bit", 1'b0, c[PFBW_BIT_START]);
        chk("short stall", 1'b0, core_stall);
      end
    end
    chk("skip before", 1'b0, instr_skip);
    retire;
    chk("skip slot", 1'b1, instr_skip);
    retire;
    n = 0;
    while (core_stall !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("flash_prog", 1'b1, flash_prog);
    chk("block base", base, flash_addr);
    chk("block data", ex, flash_data);
    n = 0;
    while (core_stall !== 1'b0 && n < LONG + 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("stall length ok", 1'b1, n >= LONG - 2 && n <= LONG + 2);
    chk("buffer blank", BLANK, flash_data);
  endtask : block
  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    #40000;
    mismatches++;
    wrap_up;
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    mismatches = 0;
    compares = 0;
    reset_n = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    instr_retire = 1'b0;
    clk_en = 1'b1;
    flash_done_async = 1'b0;
    write_protect_config = 2'h3;
    rows = '{
      '{PFBW_IDX_FLAGS, 8'h00, 1'b0, 8'h00}, '{PFBW_IDX_ENABLES, 8'h00, 1'b0, 8'h00},
      '{PFBW_IDX_ENABLES, 8'hff, 1'b1, 8'h10}, '{PFBW_IDX_ENABLES, 8'h00, 1'b1, 8'h00},
      '{PFBW_IDX_FLAGS, 8'hff, 1'b1, 8'h10}, '{PFBW_IDX_FLAGS, 8'h00, 1'b1, 8'h00},
      '{PFBW_IDX_ADDR_LO, 8'h5a, 1'b1, 8'h5a}, '{PFBW_IDX_DATA_LO, 8'ha5, 1'b1, 8'ha5},
      '{10'h3ff, 8'h00, 1'b0, 8'h00}};
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk("reset buffer", BLANK, flash_data);
    chk("reset stall", 1'b0, core_stall);
    chk("reset irq", 1'b0, irq_req);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("register row", rows[i].e, v);
    end
    // Flag rises on completion with every enable off
    block(12'h104, 14'h1a50);
    rd(PFBW_IDX_FLAGS, v);
    chk("done flag", 8'h10, v);
    chk("irq off", 1'b0, irq_req);
    wr(PFBW_IDX_ENABLES, 8'h10);
    wr(PFBW_IDX_INTCTL, 8'h80);
    #1 chk("irq no gate", 1'b0, irq_req);
    wr(PFBW_IDX_INTCTL, 8'hc0);
    #1 chk("irq gated", 1'b1, irq_req);
    wr(PFBW_IDX_FLAGS, 8'h00);
    #1 chk("irq cleared", 1'b0, irq_req);
    // Start with no unlock, then with a broken unlock pair
    load(12'h10b, 14'h0123, 1'b0);
    wr(PFBW_IDX_UNLOCK, PFBW_UNLOCK_1);
    wr(PFBW_IDX_ADDR_LO, 8'h0b);
    wr(PFBW_IDX_UNLOCK, PFBW_UNLOCK_2);
    wr(PFBW_IDX_CONTROL, 8'h86);
    retire;
    retire;
    chk("refused stall", 1'b0, core_stall);
    chk("refused buffer", BLANK, flash_data);
    block(12'h108, 14'h3c01);
    chk("irq done", 1'b1, irq_req);
    // Fully protected array refuses the copy
    @(posedge core_clk);
    write_protect_config <= 2'h0;
    load(12'h204, 14'h0777, 1'b1);
    rd(PFBW_IDX_CONTROL, v);
    chk("protect error", 1'b1, v[PFBW_BIT_ERRFLAG]);
    chk("protect buffer", BLANK, flash_data);
    // Array reports done early: stall ends after the synchroniser delay
    @(posedge core_clk);
    write_protect_config <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      load(12'h10c + 12'(i), 14'h0200 + 14'(i), 1'b1);
    end
    retire;
    retire;
    chk("early stall", 1'b1, core_stall);
    @(posedge core_clk);
    flash_done_async <= 1'b1;
    v = 8'h00;
    while (core_stall !== 1'b0 && v < 8'(LONG + 20)) begin
      @(posedge core_clk);
      #1 v++;
    end
    chk("early done", 1'b1, v >= 8'h3 && v < 8'h8);
    chk("early blank", BLANK, flash_data);
    @(posedge core_clk);
    flash_done_async <= 1'b0;
    // Clock enable low freezes every register
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(PFBW_IDX_ADDR_LO, 8'h33);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(PFBW_IDX_ADDR_LO, v);
    chk("frozen write", 8'h0f, v);
    wrap_up;
  end
endmodule : test_pfbw_writer
